// file: shp_regs.vh
// Register offsets, control word fields and port C line positions of the strobed port.
`ifndef SHP_REGS_VH
`define SHP_REGS_VH

// Register offsets on the host I/O bus
`define SHP_OFS_PORT_A        2'h0
`define SHP_OFS_PORT_B        2'h1
`define SHP_OFS_PORT_C        2'h2
`define SHP_OFS_CONFIG        2'h3

// Control word fields
`define SHP_CFG_RESET         8'h9B
`define SHP_CFG_MODE_DEF      7
`define SHP_CFG_A_MODE1       5
`define SHP_CFG_A_INPUT       4
`define SHP_CFG_CU_INPUT      3
`define SHP_CFG_B_MODE1       2
`define SHP_CFG_B_INPUT       1
`define SHP_CFG_CL_INPUT      0

// Single bit set/reset command fields
`define SHP_BSR_SEL_HI        3
`define SHP_BSR_SEL_LO        1
`define SHP_BSR_VALUE         0

// Port C line positions in strobed mode
`define SHP_PC_INTR_A         3
`define SHP_PC_STROBE_A       4
`define SHP_PC_IN_FULL_A      5
`define SHP_PC_ACK_A          6
`define SHP_PC_OUT_FULL_A     7
`define SHP_PC_HS_B           2
`define SHP_PC_FULL_B         1
`define SHP_PC_INTR_B         0

// Set/reset selectors that reach the interrupt enables
`define SHP_SEL_INTE_A_IN     3'h4
`define SHP_SEL_INTE_A_OUT    3'h6
`define SHP_SEL_INTE_B        3'h2

// Reset values of the data latches
`define SHP_DATA_RESET        8'h00

`endif

// file: shp_fall_det.v
// Falling edge detector for an active-low strobe or acknowledge line.
`timescale 1ns/1ps
module shp_fall_det (
	input  wire i_clk,
	input  wire i_reset_n,
	input  wire i_ce,
	input  wire i_line_n,
	output wire o_fall
);
	reg line_prev_ff;

	// Idle level is high so a line held low at reset gives an edge on the first enabled cycle
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			line_prev_ff <= 1'b1;
		end else if (i_ce) begin
			line_prev_ff <= i_line_n;
		end
	end

	assign o_fall = i_ce & line_prev_ff & ~i_line_n;
endmodule

// file: shp_fifo2.v
// Two-entry byte buffer with valid/ready on both sides and a flush.
`timescale 1ns/1ps
module shp_fifo2 #(
	parameter W = 8
) (
	input  wire         i_clk,
	input  wire         i_reset_n,
	input  wire         i_ce,
	input  wire         i_flush,
	input  wire         i_in_valid,
	output wire         o_in_ready,
	input  wire [W-1:0] i_in_data,
	output wire         o_out_valid,
	input  wire         i_out_ready,
	output wire [W-1:0] o_out_data
);
	reg [W-1:0] slot0_ff;
	reg [W-1:0] slot1_ff;
	reg         wr_ptr_ff;
	reg         rd_ptr_ff;
	reg [1:0]   count_ff;
	wire        push;
	wire        pop;

	assign o_in_ready  = (count_ff != 2'h2);
	assign o_out_valid = (count_ff != 2'h0);
	assign push        = i_ce & ~i_flush & i_in_valid & o_in_ready;
	assign pop         = i_ce & ~i_flush & i_out_ready & o_out_valid;
	assign o_out_data  = rd_ptr_ff ? slot1_ff : slot0_ff;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slot0_ff  <= {W{1'b0}};
			slot1_ff  <= {W{1'b0}};
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff  <= 2'h0;
		end else if (i_ce) begin
			if (i_flush) begin
				wr_ptr_ff <= 1'b0;
				rd_ptr_ff <= 1'b0;
				count_ff  <= 2'h0;
			end else begin
				if (push) begin
					if (wr_ptr_ff) begin
						slot1_ff <= i_in_data;
					end else begin
						slot0_ff <= i_in_data;
					end
					wr_ptr_ff <= ~wr_ptr_ff;
				end
				if (pop) begin
					rd_ptr_ff <= ~rd_ptr_ff;
				end
				if (push & ~pop) begin
					count_ff <= count_ff + 2'h1;
				end else if (pop & ~push) begin
					count_ff <= count_ff - 2'h1;
				end
			end
		end
	end
endmodule

// file: shp_strobed_port.v
// Strobed handshake parallel port: two 8-bit data ports, port C status and control word.
//
// Notes on behaviour
// - Two groups: data port plus three C lines
// - Each strobed data port is input or output
// - Port A input leaves C lines 6-7 free
// - Both handshaking leaves port B no spare lines
// - Input status word layout on port C read
// - Port A input-full high after strobed capture
// - Port B input-full high after strobed capture
// - Port A request equals enable and input-full
// - Port B request equals enable and input-full
// - Port A enable via bit set/reset of line4
// - Port B enable via bit set/reset of line2
// - Input status word hides strobe line levels
// - Port A output leaves C lines 4-5 free
// - Output status word layout on port C read
// - Input and output status layouts differ
// - Output status word hides acknowledge line levels
// - Control write with bit 7 defines modes
// - Control write sets or clears one C bit
`timescale 1ns/1ps
`include "shp_regs.vh"
module shp_strobed_port (
	input  wire       i_clk,
	input  wire       i_reset_n,
	input  wire       i_ce,
	input  wire [1:0] i_addr,
	input  wire       i_iow,
	input  wire       i_ior,
	input  wire [7:0] i_wdata,
	output wire [7:0] o_rdata,
	output wire       o_rvalid,
	input  wire [7:0] i_pa,
	output wire [7:0] o_pa,
	output wire       o_pa_oe_n,
	input  wire [7:0] i_pb,
	output wire [7:0] o_pb,
	output wire       o_pb_oe_n,
	input  wire [7:0] i_pc,
	output wire [7:0] o_pc,
	output wire [7:0] o_pc_oe_n,
	output wire       o_port_a_push_ready,
	output wire       o_port_b_push_ready
);
	reg  [7:0] cfg_ff;
	reg  [7:0] pa_out_ff;
	reg  [7:0] pb_out_ff;
	reg  [7:0] pc_out_ff;
	reg        first_irq_enable_ff;
	reg        second_irq_enable_ff;
	reg  [7:0] rdata_ff;
	reg        rvalid_ff;

	reg  [7:0] nxt_pc_out;
	reg  [7:0] nxt_rdata;
	reg  [7:0] pc_drive;
	reg  [7:0] pc_oe_n;
	reg  [7:0] pc_status;
	reg  [7:0] hs_mask;

	wire       a_hs;
	wire       b_hs;
	wire       a_in;
	wire       b_in;
	wire       wr_cfg;
	wire       mode_def;
	wire       bit_cmd;
	wire [2:0] bit_sel;
	wire       bit_val;
	wire       wr_a;
	wire       wr_b;
	wire       wr_c;
	wire       rd_a;
	wire       rd_b;

	wire       first_strobe_n;
	wire       second_strobe_n;
	wire       first_acknowledge_n;
	wire       second_acknowledge_n;
	wire       a_line_n;
	wire       b_line_n;
	wire       a_fall;
	wire       b_fall;

	wire       a_push;
	wire       b_push;
	wire       a_pop;
	wire       b_pop;
	wire [7:0] a_push_data;
	wire [7:0] b_push_data;
	wire       a_valid;
	wire       b_valid;
	wire [7:0] a_head;
	wire [7:0] b_head;

	wire       first_input_full;
	wire       second_input_full;
	wire       first_output_full_n;
	wire       second_output_full_n;
	wire       first_irq_request;
	wire       second_irq_request;
	wire [7:0] pc_gp_read;

	// Mode decode from the control word
	assign a_hs = cfg_ff[`SHP_CFG_A_MODE1];
	assign b_hs = cfg_ff[`SHP_CFG_B_MODE1];
	assign a_in = cfg_ff[`SHP_CFG_A_INPUT];
	assign b_in = cfg_ff[`SHP_CFG_B_INPUT];

	// Host bus decode
	assign wr_cfg   = i_ce & i_iow & (i_addr == `SHP_OFS_CONFIG);
	assign mode_def = wr_cfg & i_wdata[`SHP_CFG_MODE_DEF];
	assign bit_cmd  = wr_cfg & ~i_wdata[`SHP_CFG_MODE_DEF];
	assign bit_sel  = i_wdata[`SHP_BSR_SEL_HI:`SHP_BSR_SEL_LO];
	assign bit_val  = i_wdata[`SHP_BSR_VALUE];
	assign wr_a     = i_ce & i_iow & (i_addr == `SHP_OFS_PORT_A);
	assign wr_b     = i_ce & i_iow & (i_addr == `SHP_OFS_PORT_B);
	assign wr_c     = i_ce & i_iow & (i_addr == `SHP_OFS_PORT_C);
	assign rd_a     = i_ce & i_ior & (i_addr == `SHP_OFS_PORT_A);
	assign rd_b     = i_ce & i_ior & (i_addr == `SHP_OFS_PORT_B);

	// Handshake inputs on port C
	assign first_strobe_n       = i_pc[`SHP_PC_STROBE_A];
	assign first_acknowledge_n  = i_pc[`SHP_PC_ACK_A];
	assign second_strobe_n      = i_pc[`SHP_PC_HS_B];
	assign second_acknowledge_n = i_pc[`SHP_PC_HS_B];

	// Held high outside strobed mode so no stray edge reaches the buffer
	assign a_line_n = a_hs ? (a_in ? first_strobe_n : first_acknowledge_n) : 1'b1;
	assign b_line_n = b_hs ? (b_in ? second_strobe_n : second_acknowledge_n) : 1'b1;

	shp_fall_det u_fall_a (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_line_n  (a_line_n),
		.o_fall    (a_fall)
	);

	shp_fall_det u_fall_b (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_line_n  (b_line_n),
		.o_fall    (b_fall)
	);

	// Input: strobe fills, host read drains. Output: host write fills, ack drains.
	assign a_push      = a_hs & (a_in ? a_fall : wr_a);
	assign b_push      = b_hs & (b_in ? b_fall : wr_b);
	assign a_pop       = a_hs & (a_in ? rd_a : a_fall);
	assign b_pop       = b_hs & (b_in ? rd_b : b_fall);
	assign a_push_data = a_in ? i_pa : i_wdata;
	assign b_push_data = b_in ? i_pb : i_wdata;

	shp_fifo2 #(
		.W (8)
	) u_buf_a (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_ce        (i_ce),
		.i_flush     (mode_def),
		.i_in_valid  (a_push),
		.o_in_ready  (o_port_a_push_ready),
		.i_in_data   (a_push_data),
		.o_out_valid (a_valid),
		.i_out_ready (a_pop),
		.o_out_data  (a_head)
	);

	shp_fifo2 #(
		.W (8)
	) u_buf_b (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_ce        (i_ce),
		.i_flush     (mode_def),
		.i_in_valid  (b_push),
		.o_in_ready  (o_port_b_push_ready),
		.i_in_data   (b_push_data),
		.o_out_valid (b_valid),
		.i_out_ready (b_pop),
		.o_out_data  (b_head)
	);

	// Status flags
	assign first_input_full     = a_valid;
	assign second_input_full    = b_valid;
	assign first_output_full_n  = ~a_valid;
	assign second_output_full_n = ~b_valid;
	assign first_irq_request    = a_in ? (first_irq_enable_ff & first_input_full)
	                                   : (first_irq_enable_ff & first_output_full_n);
	assign second_irq_request   = b_in ? (second_irq_enable_ff & second_input_full)
	                                   : (second_irq_enable_ff & second_output_full_n);

	// Lines owned by the handshake, not writable as general purpose
	always @* begin
		hs_mask = 8'h00;
		if (a_hs) begin
			hs_mask[`SHP_PC_INTR_A] = 1'b1;
			if (a_in) begin
				hs_mask[`SHP_PC_STROBE_A]  = 1'b1;
				hs_mask[`SHP_PC_IN_FULL_A] = 1'b1;
			end else begin
				hs_mask[`SHP_PC_ACK_A]      = 1'b1;
				hs_mask[`SHP_PC_OUT_FULL_A] = 1'b1;
			end
		end
		if (b_hs) begin
			hs_mask[`SHP_PC_HS_B:`SHP_PC_INTR_B] = 3'h7;
		end
	end

	// Port C output latch
	always @* begin
		nxt_pc_out = pc_out_ff;
		if (mode_def) begin
			nxt_pc_out = `SHP_DATA_RESET;
		end else if (wr_c) begin
			// Plain writes touch only spare lines; handshake lines keep their role
			nxt_pc_out = (pc_out_ff & hs_mask) | (i_wdata & ~hs_mask);
		end else if (bit_cmd & ~hs_mask[bit_sel]) begin
			nxt_pc_out[bit_sel] = bit_val;
		end
	end

	// Port C drive and enables
	always @* begin
		pc_drive = pc_out_ff;
		pc_oe_n  = {{4{cfg_ff[`SHP_CFG_CU_INPUT]}}, {4{cfg_ff[`SHP_CFG_CL_INPUT]}}};
		if (a_hs) begin
			pc_drive[`SHP_PC_INTR_A] = first_irq_request;
			pc_oe_n[`SHP_PC_INTR_A]  = 1'b0;
			if (a_in) begin
				pc_drive[`SHP_PC_IN_FULL_A] = first_input_full;
				pc_oe_n[`SHP_PC_IN_FULL_A]  = 1'b0;
				pc_oe_n[`SHP_PC_STROBE_A]   = 1'b1;
			end else begin
				pc_drive[`SHP_PC_OUT_FULL_A] = first_output_full_n;
				pc_oe_n[`SHP_PC_OUT_FULL_A]  = 1'b0;
				pc_oe_n[`SHP_PC_ACK_A]       = 1'b1;
			end
		end
		if (b_hs) begin
			pc_drive[`SHP_PC_FULL_B] = b_in ? second_input_full : second_output_full_n;
			pc_drive[`SHP_PC_INTR_B] = second_irq_request;
			pc_oe_n[`SHP_PC_FULL_B]  = 1'b0;
			pc_oe_n[`SHP_PC_INTR_B]  = 1'b0;
			pc_oe_n[`SHP_PC_HS_B]    = 1'b1;
		end
	end

	// Spare lines read back the pin when input, the latch when output
	assign pc_gp_read = (pc_oe_n & i_pc) | (~pc_oe_n & pc_out_ff);

	// Status word; enables sit where the strobe or ack level would be
	always @* begin
		pc_status = pc_gp_read;
		if (a_hs) begin
			pc_status[`SHP_PC_INTR_A] = first_irq_request;
			if (a_in) begin
				pc_status[`SHP_PC_IN_FULL_A] = first_input_full;
				pc_status[`SHP_PC_STROBE_A]  = first_irq_enable_ff;
			end else begin
				pc_status[`SHP_PC_OUT_FULL_A] = first_output_full_n;
				pc_status[`SHP_PC_ACK_A]      = first_irq_enable_ff;
			end
		end
		if (b_hs) begin
			pc_status[`SHP_PC_HS_B]   = second_irq_enable_ff;
			pc_status[`SHP_PC_FULL_B] = b_in ? second_input_full
			                                 : second_output_full_n;
			pc_status[`SHP_PC_INTR_B] = second_irq_request;
		end
	end

	// Read data mux
	always @* begin
		nxt_rdata = 8'h00;
		case (i_addr)
			`SHP_OFS_PORT_A: begin
				if (a_hs) begin
					nxt_rdata = a_head;
				end else begin
					nxt_rdata = a_in ? i_pa : pa_out_ff;
				end
			end
			`SHP_OFS_PORT_B: begin
				if (b_hs) begin
					nxt_rdata = b_head;
				end else begin
					nxt_rdata = b_in ? i_pb : pb_out_ff;
				end
			end
			`SHP_OFS_PORT_C: begin
				nxt_rdata = pc_status;
			end
			default: begin
				// Control word is write-only
				nxt_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_ff               <= `SHP_CFG_RESET;
			pa_out_ff            <= `SHP_DATA_RESET;
			pb_out_ff            <= `SHP_DATA_RESET;
			pc_out_ff            <= `SHP_DATA_RESET;
			first_irq_enable_ff  <= 1'b0;
			second_irq_enable_ff <= 1'b0;
			rdata_ff             <= 8'h00;
			rvalid_ff            <= 1'b0;
		end else if (i_ce) begin
			pc_out_ff <= nxt_pc_out;
			rvalid_ff <= i_ior;
			if (i_ior) begin
				rdata_ff <= nxt_rdata;
			end
			if (mode_def) begin
				// A new mode starts with empty latches and interrupts off
				cfg_ff               <= i_wdata;
				pa_out_ff            <= `SHP_DATA_RESET;
				pb_out_ff            <= `SHP_DATA_RESET;
				first_irq_enable_ff  <= 1'b0;
				second_irq_enable_ff <= 1'b0;
			end else begin
				if (wr_a & ~a_hs) begin
					pa_out_ff <= i_wdata;
				end
				if (wr_b & ~b_hs) begin
					pb_out_ff <= i_wdata;
				end
				if (bit_cmd & a_hs & (bit_sel == (a_in ? `SHP_SEL_INTE_A_IN
				                                       : `SHP_SEL_INTE_A_OUT))) begin
					first_irq_enable_ff <= bit_val;
				end
				if (bit_cmd & b_hs & (bit_sel == `SHP_SEL_INTE_B)) begin
					second_irq_enable_ff <= bit_val;
				end
			end
		end
	end

	assign o_rdata   = rdata_ff;
	assign o_rvalid  = rvalid_ff;
	assign o_pa      = (a_hs & ~a_in) ? a_head : pa_out_ff;
	assign o_pa_oe_n = a_in;
	assign o_pb      = (b_hs & ~b_in) ? b_head : pb_out_ff;
	assign o_pb_oe_n = b_in;
	assign o_pc      = pc_drive;
	assign o_pc_oe_n = pc_oe_n;
endmodule

// file: shp_strobed_port_checker.sv
// Assertion checker for the strobed port, attached by bind.
`timescale 1ns/1ps
module shp_strobed_port_checker (
	input logic       i_clk,
	input logic       i_reset_n,
	input logic       i_ce,
	input logic [1:0] i_addr,
	input logic       i_iow,
	input logic       i_ior,
	input logic [7:0] i_wdata,
	input logic [7:0] o_rdata,
	input logic       o_rvalid,
	input logic       o_pa_oe_n,
	input logic [7:0] i_pc,
	input logic [7:0] o_pc,
	input logic [7:0] o_pc_oe_n,
	input logic       o_port_a_push_ready,
	input logic       o_port_b_push_ready
);
	logic [7:0] cfg_ff;
	logic       rd_c_ff;
	wire        a_in  = cfg_ff[5] & cfg_ff[4];
	wire        a_out = cfg_ff[5] & ~cfg_ff[4];
	wire        b_in  = cfg_ff[2] & cfg_ff[1];

	// Shadow of the mode so status checks know which layout applies
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_ff  <= 8'h9B;
			rd_c_ff <= 1'b0;
		end else if (i_ce) begin
			if (i_iow && i_addr == 2'h3 && i_wdata[7])
				cfg_ff <= i_wdata;
			if (i_ior)
				rd_c_ff <= (i_addr == 2'h2);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	chk_read_answer: assert property ((i_ce && i_ior) |=> o_rvalid)
		else $error("read not answered");
	chk_read_single: assert property ((i_ce && !i_ior) |=> !o_rvalid)
		else $error("stray read valid");
	chk_cfg_read: assert property ((i_ce && i_ior && i_addr == 2'h3) |=> o_rdata == 8'h00)
		else $error("control read not zero");
	chk_a_request: assert property ((o_rvalid && rd_c_ff && cfg_ff[5]) |->
		o_rdata[3] == (a_in ? o_rdata[4] & o_rdata[5] : o_rdata[6] & o_rdata[7]))
		else $error("port A request wrong");
	chk_b_request: assert property ((o_rvalid && rd_c_ff && cfg_ff[2]) |->
		o_rdata[0] == (o_rdata[2] & o_rdata[1])) else $error("port B request wrong");
	chk_a_in_dirs: assert property (a_in |->
		(o_pc_oe_n[4] && !o_pc_oe_n[5] && !o_pc_oe_n[3] && o_pa_oe_n))
		else $error("port A input directions");
	chk_a_out_dirs: assert property (a_out |->
		(o_pc_oe_n[6] && !o_pc_oe_n[7] && !o_pc_oe_n[3] && !o_pa_oe_n))
		else $error("port A output directions");
	chk_b_dirs: assert property (cfg_ff[2] |->
		(o_pc_oe_n[2] && o_pc_oe_n[1:0] == 2'b00))
		else $error("port B handshake directions");
	chk_a_capture: assert property ((i_ce && a_in && $fell(i_pc[4]) &&
		o_port_a_push_ready) |=> o_pc[5]) else $error("port A full not raised");
	chk_b_capture: assert property ((i_ce && b_in && $fell(i_pc[2]) &&
		o_port_b_push_ready) |=> o_pc[1]) else $error("port B full not raised");
	chk_a_full_n: assert property ((a_out && i_ce && i_iow && i_addr == 2'h0 &&
		o_port_a_push_ready) |=> !o_pc[7]) else $error("port A output full missing");
endmodule

bind shp_strobed_port shp_strobed_port_checker chk_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_ce(i_ce), .i_addr(i_addr), .i_iow(i_iow), .i_ior(i_ior), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_pa_oe_n(o_pa_oe_n), .i_pc(i_pc), .o_pc(o_pc),
	.o_pc_oe_n(o_pc_oe_n), .o_port_a_push_ready(o_port_a_push_ready),
	.o_port_b_push_ready(o_port_b_push_ready));

// file: shp_periph_model.sv
// Peripheral model: strobes bytes in and acknowledges bytes out.
`timescale 1ns/1ps
module shp_periph_model (
	input  logic       i_clk,
	output logic [7:0] o_pa,
	output logic [7:0] o_pb,
	output logic [7:0] o_pc
);
	// Handshake lines rest high, as if pulled up
	initial begin
		o_pa = 8'h00;
		o_pb = 8'h00;
		o_pc = 8'hFF;
	end

	task automatic strobe(input logic sel_b, input logic [7:0] d, input int slow);
		int k;
		k = sel_b ? 2 : 4;
		@(negedge i_clk);
		o_pa = sel_b ? o_pa : d;
		o_pb = sel_b ? d : o_pb;
		o_pc[k] = 1'b0;
		repeat (slow + 1) @(negedge i_clk);
		o_pc[k] = 1'b1;
		// Released bus flips so a stale byte cannot pass for a capture
		o_pa = sel_b ? o_pa : ~d;
		o_pb = sel_b ? ~d : o_pb;
		@(negedge i_clk);
	endtask

	task automatic ack(input logic sel_b, input int slow);
		int k;
		k = sel_b ? 2 : 6;
		repeat (slow + 1) @(negedge i_clk);
		o_pc[k] = 1'b0;
		@(negedge i_clk);
		o_pc[k] = 1'b1;
		@(negedge i_clk);
	endtask
endmodule

// file: tb_top.sv
// Self-checking bench: host bus tasks against the peripheral model.
`timescale 1ns/1ps
`define chk_eq(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module tb_top;
	logic       i_clk     = 1'b0;
	logic       i_reset_n = 1'b0;
	logic       i_ce      = 1'b1;
	logic [1:0] i_addr    = 2'h0;
	logic       i_iow     = 1'b0;
	logic       i_ior     = 1'b0;
	logic [7:0] i_wdata   = 8'h00;
	logic [7:0] rd_val;
	int         err_total  = 0;
	int         num_checks = 0;
	wire  [7:0] o_rdata, o_pa, o_pb, o_pc, o_pc_oe_n, per_pa, per_pb, per_pc;
	wire        o_rvalid, o_pa_oe_n, o_pb_oe_n, rdy_a, rdy_b;
	wire  [7:0] i_pc = (o_pc_oe_n & per_pc) | (~o_pc_oe_n & o_pc);
	wire  [7:0] i_pa = o_pa_oe_n ? per_pa : o_pa;
	wire  [7:0] i_pb = o_pb_oe_n ? per_pb : o_pb;

	always #2.5 i_clk = ~i_clk;

	shp_strobed_port DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
		.i_iow(i_iow), .i_ior(i_ior), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.i_pa(i_pa), .o_pa(o_pa), .o_pa_oe_n(o_pa_oe_n), .i_pb(i_pb), .o_pb(o_pb),
		.o_pb_oe_n(o_pb_oe_n), .i_pc(i_pc), .o_pc(o_pc), .o_pc_oe_n(o_pc_oe_n),
		.o_port_a_push_ready(rdy_a), .o_port_b_push_ready(rdy_b));
	shp_periph_model u_per (.i_clk(i_clk), .o_pa(per_pa), .o_pb(per_pb), .o_pc(per_pc));

	task automatic do_reset();
		i_reset_n = 1'b0;
		repeat (6) @(negedge i_clk);
		i_reset_n = 1'b1;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_addr = a;
		i_wdata = d;
		i_iow = 1'b1;
		@(negedge i_clk);
		i_iow = 1'b0;
	endtask

	task automatic rd(input logic [1:0] a);
		int n;
		@(negedge i_clk);
		i_addr = a;
		i_ior = 1'b1;
		@(negedge i_clk);
		i_ior = 1'b0;
		for (n = 0; n < 3 && o_rvalid !== 1'b1; n++)
			@(negedge i_clk);
		`chk_eq(o_rvalid, 1'b1)
		rd_val = o_rdata;
	endtask

	task automatic rc(input logic [1:0] a, input logic [7:0] e);
		rd(a);
		`chk_eq(rd_val, e)
	endtask

	task automatic poll(input logic [7:0] mask);
		int n;
		rd(2'h2);
		for (n = 0; n < 20 && (rd_val & mask) == 8'h00; n++)
			rd(2'h2);
		`chk_eq(rd_val & mask, mask)
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		do_reset();
		rc(2'h3, 8'h00);
		wr(2'h3, 8'hB6);
		u_per.strobe(1'b0, 8'h5A, 0);
		poll(8'h20);
		`chk_eq(rd_val, 8'h20)
		wr(2'h3, 8'h09);
		wr(2'h3, 8'h05);
		wr(2'h3, 8'h0F);
		u_per.strobe(1'b0, 8'h66, 2);
		`chk_eq(rdy_a, 1'b0)
		u_per.strobe(1'b0, 8'h77, 0);
		u_per.strobe(1'b1, 8'hC3, 0);
		poll(8'h02);
		`chk_eq(rd_val, 8'hBF)
		`chk_eq({o_pc[3], o_pc[1:0]}, 3'h7)
		rc(2'h0, 8'h5A);
		rc(2'h0, 8'h66);
		rc(2'h2, 8'h97);
		rc(2'h1, 8'hC3);
		rc(2'h2, 8'h94);
		// Frozen clock enable: a strobe now must not be captured
		i_ce = 1'b0;
		u_per.strobe(1'b0, 8'h11, 0);
		i_ce = 1'b1;
		rc(2'h2, 8'h94);
		do_reset();
		wr(2'h3, 8'hA4);
		rc(2'h2, 8'h82);
		wr(2'h3, 8'h0D);
		wr(2'h3, 8'h05);
		rc(2'h2, 8'hCF);
		wr(2'h0, 8'h12);
		wr(2'h0, 8'h34);
		wr(2'h0, 8'h56);
		`chk_eq(o_pa, 8'h12)
		rc(2'h2, 8'h47);
		u_per.ack(1'b0, 2);
		`chk_eq(o_pa, 8'h34)
		u_per.ack(1'b0, 0);
		wr(2'h1, 8'hAB);
		`chk_eq(o_pb, 8'hAB)
		`chk_eq(o_pb_oe_n, 1'b0)
		rc(2'h2, 8'hCC);
		u_per.ack(1'b1, 0);
		rc(2'h2, 8'hCF);
		// Plain port C write reaches only the spare lines
		wr(2'h2, 8'h30);
		rc(2'h2, 8'hFF);
		wr(2'h3, 8'h0A);
		wr(2'h3, 8'h04);
		rc(2'h2, 8'hDA);
		close_out();
	end

	// The run takes well under a thousand cycles
	initial begin
		repeat (4000) @(posedge i_clk);
		err_total++;
		close_out();
	end
endmodule
